// file: verilog/tdesr_pkg.sv
// constants and carrier types of the triple des register block
package tdesr_pkg;

  localparam logic [7:0] TDESR_OFF_CTRL      = 8'h00;
  localparam logic [7:0] TDESR_OFF_MODE      = 8'h04;
  localparam logic [7:0] TDESR_OFF_MASK_SET  = 8'h10;
  localparam logic [7:0] TDESR_OFF_MASK_CLR  = 8'h14;
  localparam logic [7:0] TDESR_OFF_MASK_VIEW = 8'h18;
  localparam logic [7:0] TDESR_OFF_STATUS    = 8'h1C;
  localparam logic [7:0] TDESR_OFF_KEY_FIRST = 8'h20;
  localparam logic [7:0] TDESR_OFF_KEY_LAST  = 8'h34;
  localparam logic [7:0] TDESR_OFF_IN1       = 8'h40;
  localparam logic [7:0] TDESR_OFF_IN2       = 8'h44;
  localparam logic [7:0] TDESR_OFF_OUT1      = 8'h50;
  localparam logic [7:0] TDESR_OFF_OUT2      = 8'h54;
  localparam logic [7:0] TDESR_OFF_IV1       = 8'h60;
  localparam logic [7:0] TDESR_OFF_IV2       = 8'h64;

  // control word bits
  localparam int TDESR_CTRL_START = 0;
  localparam int TDESR_CTRL_SOFT_RESET_CMD = 8;

  // mode word fields
  localparam int TDESR_MODE_CIPHER = 0;
  localparam int TDESR_MODE_TRIPLE = 1;
  localparam int TDESR_MODE_KEYOPT = 4;
  localparam int TDESR_MODE_START  = 8;
  localparam int TDESR_MODE_CHAIN  = 12;
  localparam int TDESR_MODE_LOD    = 15;
  localparam int TDESR_MODE_CFBS   = 16;

  // mask and status bit positions
  localparam int TDESR_BIT_DONE = 0;
  localparam int TDESR_BIT_BAD  = 8;
  localparam int TDESR_BIT_KIND = 12;

  localparam logic [1:0] TDESR_START_MANUAL = 2'h0;
  localparam logic [1:0] TDESR_START_AUTO   = 2'h1;
  localparam logic [1:0] TDESR_START_DMA    = 2'h2;

  localparam logic [1:0] TDESR_CHAIN_ECB = 2'h0;
  localparam logic [1:0] TDESR_CHAIN_CBC = 2'h1;
  localparam logic [1:0] TDESR_CHAIN_OFB = 2'h2;
  localparam logic [1:0] TDESR_CHAIN_CFB = 2'h3;

  localparam logic [1:0] TDESR_KIND_IN_DMA   = 2'h0;
  localparam logic [1:0] TDESR_KIND_OUT_BUSY = 2'h1;
  localparam logic [1:0] TDESR_KIND_MODE     = 2'h2;
  localparam logic [1:0] TDESR_KIND_WO_READ  = 2'h3;

  localparam int TDESR_CNT_W = 16;

  typedef struct packed {
    logic [1:0] cfbs;
    logic       last_output_option;
    logic [1:0] chaining_mode;
    logic [1:0] start_mode_select;
    logic       key_count_option;
    logic       triple_select;
    logic       cipher;
  } tdesr_mode_t;

  typedef struct packed {
    logic [TDESR_CNT_W-1:0] rx_dma_count;
    logic [TDESR_CNT_W-1:0] rx_dma_next_count;
    logic [TDESR_CNT_W-1:0] tx_dma_count;
    logic [TDESR_CNT_W-1:0] tx_dma_next_count;
    logic                   rx_count_wr;
    logic                   tx_count_wr;
  } tdesr_dma_t;

  typedef struct packed {
    logic        start;
    tdesr_mode_t mode;
    logic [63:0] first_key_half;
    logic [63:0] second_key_half;
    logic [63:0] third_key_half;
    logic        second_key_used;
    logic        third_key_used;
    logic        init_vector_used;
    logic [63:0] input_half;
    logic [63:0] init_vector_half;
  } tdesr_core_t;

endpackage

// file: verilog/tdesr_regs.sv
// register front end of the triple des accelerator: apb slave, flags and key/data words
//
// Notes on behaviour
// - mask view shows enables: done bit0, rx end 1, tx end 2, full 3, empty 4, bad 8.
// - block_done_flag sets when a block encryption or decryption finishes.
// - block_done_flag clears on manual start command and on software reset.
// - option 0, manual or auto: reading an output word clears block_done_flag.
// - option 1, manual or auto: writing an input word clears block_done_flag.
// - in dma start mode block_done_flag sets and clears by itself.
// - rx end flag sets when rx count hits zero since last rx count write.
// - tx end flag sets when tx count hits zero since last tx count write.
// - rx full flag is high one cycle after both rx counts are zero, and stays high while both stay zero.
// - tx empty flag is high one cycle after both tx counts are zero, and stays high while both stay zero.
// - bad access flag is sticky; only software reset clears it.
// - bad access kind: 00 dma input write, 01 output read, 10 mode, 11 wo read.
// - bad access kind keeps the latest violation; only software reset zeroes it.
// - each key is two words, word 1 upper half, word 2 lower half.
// - key, input and vector words are write-only and read back as zero.
// - second key is ignored in single des processing.
// - third key is ignored in single des and in two-key triple des.
// - input block is two words, word 1 upper half, word 2 lower half.
// - result block reads as two words, word 1 upper half, word 2 lower half.
// - chaining and feedback modes take a two-word vector, word 1 upper half.
// - writing 1 to start begins a manual run; 0 does nothing.
// - triple select 0 uses first key only, 1 adds the second key and, with key option 0, the third.
// - key option 0 selects three keys, 1 selects two keys.
// - chaining mode 00 code book, 01 block chaining, 10 output fb, 11 cipher fb.
module tdesr_regs
  import tdesr_pkg::*;
(
  input  wire logic        clk,         // 40 MHz module clock
  input  wire logic        sys_rst,     // asynchronous reset, active high
  input  wire logic        psel,        // apb select
  input  wire logic        penable,     // apb enable
  input  wire logic        pwrite,      // apb direction, high for write
  input  wire logic [7:0]  paddr,       // apb byte address
  input  wire logic [31:0] pwdata,      // apb write data
  output logic      [31:0] prdata,      // apb read data
  output logic             pready,      // apb ready
  output logic             pslverr,     // apb error on unmapped address
  output logic             irq,         // interrupt request, active high
  input  wire tdesr_dma_t  dma,         // dma counters and counter write strobes
  input  wire logic        core_done,   // cipher core finished a block
  input  wire logic [63:0] core_result, // processed block from the core
  output tdesr_core_t      core         // keys, data, mode and start to the core
);

  typedef struct packed {
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic             irq;
    logic [5:0]       mask;
    logic             block_done_flag;
    logic             rx_dma_end_flag;
    logic             tx_dma_end_flag;
    logic             rx_dma_full_flag;
    logic             tx_dma_empty_flag;
    logic             bad_access_flag;
    logic [1:0]       bad_access_kind;
    tdesr_mode_t      mode;
    logic [0:5][31:0] key;
    logic [63:0]      input_half;
    logic [63:0]      init_vector_half;
    logic [63:0]      output_half;
    logic             busy;
    logic             start;
    logic             in1_loaded;
    logic             in2_loaded;
    logic             key2_used;
    logic             key3_used;
    logic             iv_used;
  } tdesr_state_t;

  tdesr_state_t s;
  tdesr_state_t next_s;

  logic        acc;
  logic        prep;
  logic        hit;
  logic        wo;
  logic [31:0] rv;
  logic [31:0] stat_w;
  logic [31:0] mask_w;
  logic [31:0] mode_w;
  logic        dma_mode;
  logic        sw_mode;
  logic        viol;
  logic [1:0]  vkind;
  logic        soft_reset_cmd;

  ////////////////////////////////////////////////////////////////////////////
  // register views

  assign stat_w = {18'h0, s.bad_access_kind, 3'h0, s.bad_access_flag, 3'h0,
                   s.tx_dma_empty_flag, s.rx_dma_full_flag, s.tx_dma_end_flag,
                   s.rx_dma_end_flag, s.block_done_flag};
  assign mask_w = {23'h0, s.mask[5], 3'h0, s.mask[4:0]};
  assign mode_w = {14'h0, s.mode.cfbs, s.mode.last_output_option, 1'b0,
                   s.mode.chaining_mode, 2'h0, s.mode.start_mode_select, 3'h0,
                   s.mode.key_count_option, 2'h0, s.mode.triple_select, s.mode.cipher};

  assign dma_mode = (s.mode.start_mode_select == TDESR_START_DMA);
  assign sw_mode  = (s.mode.start_mode_select == TDESR_START_MANUAL) ||
                    (s.mode.start_mode_select == TDESR_START_AUTO);
  assign prep     = psel & penable & ~s.pready;
  assign acc      = psel & penable & s.pready;

  ////////////////////////////////////////////////////////////////////////////
  // address decode

  always_comb begin
    hit = 1'b1;
    wo  = 1'b0;
    rv  = 32'h0;
    if (paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (paddr == TDESR_OFF_CTRL) begin
      wo = 1'b1;
    end else if (paddr == TDESR_OFF_MODE) begin
      rv = mode_w;
    end else if (paddr == TDESR_OFF_MASK_SET || paddr == TDESR_OFF_MASK_CLR) begin
      wo = 1'b1;
    end else if (paddr == TDESR_OFF_MASK_VIEW) begin
      rv = mask_w;
    end else if (paddr == TDESR_OFF_STATUS) begin
      rv = stat_w;
    end else if (paddr >= TDESR_OFF_KEY_FIRST && paddr <= TDESR_OFF_KEY_LAST) begin
      wo = 1'b1;
    end else if (paddr == TDESR_OFF_IN1 || paddr == TDESR_OFF_IN2) begin
      wo = 1'b1;
    end else if (paddr == TDESR_OFF_OUT1) begin
      rv = s.output_half[63:32];
    end else if (paddr == TDESR_OFF_OUT2) begin
      rv = s.output_half[31:0];
    end else if (paddr == TDESR_OFF_IV1 || paddr == TDESR_OFF_IV2) begin
      wo = 1'b1;
    end else begin
      hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_s  = s;
    viol    = 1'b0;
    vkind   = 2'h0;
    soft_reset_cmd   = 1'b0;
    next_s.start   = 1'b0;
    next_s.pready  = prep;
    next_s.pslverr = 1'b0;
    // read data is captured one cycle ahead so that prdata comes from a flop
    if (prep) begin
      next_s.prdata  = (pwrite || wo) ? 32'h0 : rv;
      next_s.pslverr = ~hit;
    end
    if (acc && hit && pwrite) begin
      if (paddr == TDESR_OFF_CTRL) begin
        soft_reset_cmd = pwdata[TDESR_CTRL_SOFT_RESET_CMD];
        if (pwdata[TDESR_CTRL_START] && s.mode.start_mode_select == TDESR_START_MANUAL
            && !s.busy) begin
          next_s.start = 1'b1;
        end
      end else if (paddr == TDESR_OFF_MODE) begin
        if (s.busy) begin
          viol  = 1'b1;
          vkind = TDESR_KIND_MODE;
        end else begin
          next_s.mode.cipher             = pwdata[TDESR_MODE_CIPHER];
          next_s.mode.triple_select      = pwdata[TDESR_MODE_TRIPLE];
          next_s.mode.key_count_option   = pwdata[TDESR_MODE_KEYOPT];
          next_s.mode.start_mode_select  = pwdata[TDESR_MODE_START+:2];
          next_s.mode.chaining_mode      = pwdata[TDESR_MODE_CHAIN+:2];
          next_s.mode.last_output_option = pwdata[TDESR_MODE_LOD];
          next_s.mode.cfbs               = pwdata[TDESR_MODE_CFBS+:2];
        end
      end else if (paddr == TDESR_OFF_MASK_SET) begin
        next_s.mask = s.mask | {pwdata[TDESR_BIT_BAD], pwdata[4:0]};
      end else if (paddr == TDESR_OFF_MASK_CLR) begin
        next_s.mask = s.mask & ~{pwdata[TDESR_BIT_BAD], pwdata[4:0]};
      end else if (paddr >= TDESR_OFF_KEY_FIRST && paddr <= TDESR_OFF_KEY_LAST) begin
        next_s.key[paddr[4:2]] = pwdata;
      end else if (paddr == TDESR_OFF_IN1 || paddr == TDESR_OFF_IN2) begin
        if (s.busy && dma_mode) begin
          viol  = 1'b1;
          vkind = TDESR_KIND_IN_DMA;
        end else begin
          if (paddr == TDESR_OFF_IN1) begin
            next_s.input_half[63:32] = pwdata;
            next_s.in1_loaded        = 1'b1;
          end else begin
            next_s.input_half[31:0] = pwdata;
            next_s.in2_loaded       = 1'b1;
          end
          if (s.mode.last_output_option && sw_mode) begin
            next_s.block_done_flag = 1'b0;
          end
        end
      end else if (paddr == TDESR_OFF_IV1) begin
        next_s.init_vector_half[63:32] = pwdata;
      end else if (paddr == TDESR_OFF_IV2) begin
        next_s.init_vector_half[31:0] = pwdata;
      end
    end
    if (acc && hit && !pwrite) begin
      if (wo) begin
        viol  = 1'b1;
        vkind = TDESR_KIND_WO_READ;
      end else if (paddr == TDESR_OFF_OUT1 || paddr == TDESR_OFF_OUT2) begin
        if (s.busy) begin
          viol  = 1'b1;
          vkind = TDESR_KIND_OUT_BUSY;
        end else if (!s.mode.last_output_option && sw_mode) begin
          next_s.block_done_flag = 1'b0;
        end
      end
    end
    if (viol) begin
      next_s.bad_access_flag = 1'b1;
      next_s.bad_access_kind = vkind;
    end
    // auto and dma modes start once both input words are loaded
    if (!sw_mode || s.mode.start_mode_select == TDESR_START_AUTO) begin
      if (s.mode.start_mode_select != 2'h3 && s.in1_loaded && s.in2_loaded && !s.busy) begin
        next_s.start = 1'b1;
      end
    end
    if (next_s.start) begin
      next_s.busy       = 1'b1;
      next_s.in1_loaded = 1'b0;
      next_s.in2_loaded = 1'b0;
      if (s.mode.start_mode_select != TDESR_START_AUTO) begin
        next_s.block_done_flag = 1'b0;
      end
    end
    // completion is applied after the access and start clears so that it wins over them; software reset still wins
    if (core_done && s.busy) begin
      next_s.busy            = 1'b0;
      next_s.output_half     = core_result;
      next_s.block_done_flag = 1'b1;
    end
    if (dma.rx_dma_count == '0) begin
      next_s.rx_dma_end_flag = 1'b1;
    end else if (dma.rx_count_wr) begin
      next_s.rx_dma_end_flag = 1'b0;
    end
    if (dma.tx_dma_count == '0) begin
      next_s.tx_dma_end_flag = 1'b1;
    end else if (dma.tx_count_wr) begin
      next_s.tx_dma_end_flag = 1'b0;
    end
    next_s.rx_dma_full_flag  = (dma.rx_dma_count == '0) && (dma.rx_dma_next_count == '0);
    next_s.tx_dma_empty_flag = (dma.tx_dma_count == '0) && (dma.tx_dma_next_count == '0);
    next_s.irq = |(stat_w[TDESR_BIT_BAD:TDESR_BIT_DONE] & mask_w[TDESR_BIT_BAD:TDESR_BIT_DONE]);
    // key and vector usage is registered so that the core sees flop outputs only
    next_s.key2_used = next_s.mode.triple_select;
    next_s.key3_used = next_s.mode.triple_select & ~next_s.mode.key_count_option;
    next_s.iv_used   = (next_s.mode.chaining_mode != TDESR_CHAIN_ECB);
    if (soft_reset_cmd) begin
      next_s = '0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign irq     = s.irq;

  assign core.start            = s.start;
  assign core.mode             = s.mode;
  assign core.first_key_half   = {s.key[0], s.key[1]};
  assign core.second_key_half  = {s.key[2], s.key[3]};
  assign core.third_key_half   = {s.key[4], s.key[5]};
  assign core.second_key_used  = s.key2_used;
  assign core.third_key_used   = s.key3_used;
  assign core.init_vector_used = s.iv_used;
  assign core.input_half       = s.input_half;
  assign core.init_vector_half = s.init_vector_half;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_mask_view_read: assert property (
    (prep && !pwrite && paddr == TDESR_OFF_MASK_VIEW) |=> (prdata == $past(mask_w) && pready))
    else $error("mask view read returned wrong data");

  a_done_sets_flag: assert property (
    (core_done && s.busy) |=> (s.block_done_flag && s.output_half == $past(core_result)))
    else $error("finished block did not set done flag");

  a_start_clears_done: assert property (
    (acc && pwrite && paddr == TDESR_OFF_CTRL && pwdata[TDESR_CTRL_START] && !s.busy
     && s.mode.start_mode_select == TDESR_START_MANUAL) |=> (!s.block_done_flag && s.busy))
    else $error("manual start did not clear done flag");

  a_out_read_clears: assert property (
    (acc && !pwrite && paddr == TDESR_OFF_OUT1 && !s.busy && sw_mode
     && !s.mode.last_output_option) |=> !s.block_done_flag)
    else $error("output read did not clear done flag");

  a_in_write_clears: assert property (
    (acc && pwrite && (paddr == TDESR_OFF_IN1 || paddr == TDESR_OFF_IN2) && !s.busy
     && sw_mode && s.mode.last_output_option) |=> !s.block_done_flag)
    else $error("input write did not clear done flag");

  a_bad_flag_sticky: assert property (
    (s.bad_access_flag && !(acc && pwrite && paddr == TDESR_OFF_CTRL
     && pwdata[TDESR_CTRL_SOFT_RESET_CMD])) |=> s.bad_access_flag)
    else $error("bad access flag dropped without software reset");

  a_wo_read_kind: assert property (
    (acc && !pwrite && paddr == TDESR_OFF_KEY_FIRST) |=>
      (s.bad_access_flag && s.bad_access_kind == TDESR_KIND_WO_READ))
    else $error("write-only read not reported");

  a_full_flag_level: assert property (
    !soft_reset_cmd |=> (s.rx_dma_full_flag == ($past(dma.rx_dma_count) == '0
         && $past(dma.rx_dma_next_count) == '0)))
    else $error("rx full flag does not follow counters");

  a_empty_flag_level: assert property (
    !soft_reset_cmd |=> (s.tx_dma_empty_flag == ($past(dma.tx_dma_count) == '0
         && $past(dma.tx_dma_next_count) == '0)))
    else $error("tx empty flag does not follow counters");

  // software reset zeroes flags and mask together, so its cycle is left out
  a_irq_follows: assert property (
    !soft_reset_cmd |=> (irq == $past(|(stat_w[8:0] & mask_w[8:0]))))
    else $error("interrupt does not follow masked status");

endmodule

// file: test/tdesr_core_model.sv
// behavioural cipher core: answers each start with a done pulse and a mixed block
module tdesr_core_model
  import tdesr_pkg::*;
#(
  parameter int LATENCY = 24          // cycles from start to done
) (
  input  wire logic        clk,         // module clock
  input  wire logic        sys_rst,     // asynchronous reset, active high
  input  wire tdesr_core_t core,        // keys, data, mode and start
  output logic             core_done,   // block finished pulse
  output logic [63:0]      core_result  // processed block
);
  timeunit 1ns;
  timeprecision 1ps;
  int          cnt;
  logic [63:0] mix;
  always_comb begin
    mix = core.input_half ^ core.first_key_half;
    // unused keys and vector never reach the result
    if (core.second_key_used) mix = mix ^ core.second_key_half;
    if (core.third_key_used) mix = mix ^ core.third_key_half;
    if (core.init_vector_used) mix = mix ^ core.init_vector_half;
  end
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      core_done <= 1'b0;
      core_result <= 64'h0;
    end else begin
      core_done <= 1'b0;
      // result toggles outside the done cycle, so late sampling shows
      core_result <= ~core_result;
      if (core.start) begin
        cnt <= LATENCY;
      end else if (cnt == 1) begin
        cnt <= 0;
        core_done <= 1'b1;
        core_result <= mix;
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule

// file: test/tb_tdesr_regs.sv
// self-checking bench of the triple des register block
module tb_tdesr_regs
  import tdesr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq, er;
  logic        core_done;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [63:0] core_result, exp;
  tdesr_dma_t  dma;
  tdesr_core_t core;
  int          miscompares, cmp_count, cycles;

  tdesr_regs u_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .dma(dma), .core_done(core_done),
    .core_result(core_result), .core(core));
  tdesr_core_model u_core (.clk(clk), .sys_rst(sys_rst), .core(core),
    .core_done(core_done), .core_result(core_result));
  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [63:0] e, input logic [63:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // hold the request until the edge that samples pready high; only the timeout ends this
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
    // let the written value settle before outputs are looked at
    @(negedge clk);
  endtask

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd, er);
    check(nm, e, rd & m);
  endtask

  task automatic wait_done;
    int n;
    n = 0;
    do begin
      apb(1'b0, TDESR_OFF_STATUS, 32'h0, rd, er);
      n++;
    end while (rd[0] !== 1'b1 && n < 40);
    check("done flag", 1'b1, rd[0]);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_mask;
    int b [6] = '{0, 1, 2, 3, 4, 8};
    rchk("status reset", TDESR_OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
    foreach (b[i]) begin
      wr(TDESR_OFF_MASK_SET, 32'h1 << b[i]);
      rchk("mask view", TDESR_OFF_MASK_VIEW, 32'hFFFF_FFFF, 32'h1 << b[i]);
      wr(TDESR_OFF_MASK_CLR, 32'h1 << b[i]);
    end
    wr(TDESR_OFF_MASK_SET, 32'hFFFF_FFFF);
    rchk("mask all", TDESR_OFF_MASK_VIEW, 32'hFFFF_FFFF, 32'h0000_011F);
    wr(TDESR_OFF_MASK_CLR, 32'hFFFF_FFFF);
  endtask

  task automatic t_wo_read;
    logic [7:0] a [6] = '{8'h20, 8'h34, 8'h40, 8'h44, 8'h60, 8'h64};
    foreach (a[i]) rchk("wo read", a[i], 32'hFFFF_FFFF, 32'h0);
    rchk("bad kind 3", TDESR_OFF_STATUS, 32'hFFFF_FFFF, 32'h0000_3100);
    apb(1'b0, 8'h03, 32'h0, rd, er);
    check("unmapped err", 1'b1, er);
  endtask

  task automatic t_config;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      wr(TDESR_OFF_MODE, (32'(c) << 12) | (32'(c[1]) << 4) | (32'(c[0]) << 1));
      check("chaining", c, core.mode.chaining_mode);
      check("key2 used", c[0], core.second_key_used);
      check("key3 used", c[0] & ~c[1], core.third_key_used);
      check("iv used", c != TDESR_CHAIN_ECB, core.init_vector_used);
    end
  endtask

  task automatic t_manual;
    wr(TDESR_OFF_MODE, 32'h0000_1003);
    for (int j = 0; j < 6; j++) wr(8'(TDESR_OFF_KEY_FIRST + 4 * j), 32'h1111_1111 * (j + 1));
    wr(TDESR_OFF_IV1, 32'hA5A5_A5A5);
    wr(TDESR_OFF_IV2, 32'h5A5A_0F0F);
    wr(TDESR_OFF_IN1, 32'h0123_4567);
    wr(TDESR_OFF_IN2, 32'h89AB_CDEF);
    check("key1", {32'h1111_1111, 32'h2222_2222}, core.first_key_half);
    check("key3", {32'h5555_5555, 32'h6666_6666}, core.third_key_half);
    check("input", 64'h0123_4567_89AB_CDEF, core.input_half);
    check("vector", 64'hA5A5_A5A5_5A5A_0F0F, core.init_vector_half);
    exp = 64'h0123_4567_89AB_CDEF ^ {32'h1111_1111, 32'h2222_2222} ^ 64'hA5A5_A5A5_5A5A_0F0F
        ^ {32'h3333_3333, 32'h4444_4444} ^ {32'h5555_5555, 32'h6666_6666};
    wr(TDESR_OFF_MASK_SET, 32'h1);
    wr(TDESR_OFF_CTRL, 32'h0);
    rchk("no start", TDESR_OFF_STATUS, 32'h1, 32'h0);
    wr(TDESR_OFF_CTRL, 32'h1);
    rchk("busy out", TDESR_OFF_OUT1, 32'hFFFF_FFFF, 32'h0);
    rchk("kind 1", TDESR_OFF_STATUS, 32'h3100, 32'h1100);
    wr(TDESR_OFF_MODE, 32'h0);
    check("mode kept", TDESR_CHAIN_CBC, core.mode.chaining_mode);
    wait_done;
    rchk("kind 2", TDESR_OFF_STATUS, 32'hFFFF_FFFF, 32'h2101);
    check("irq on", 1'b1, irq);
    rchk("out1", TDESR_OFF_OUT1, 32'hFFFF_FFFF, exp[63:32]);
    rchk("out2", TDESR_OFF_OUT2, 32'hFFFF_FFFF, exp[31:0]);
    rchk("read clears", TDESR_OFF_STATUS, 32'h1, 32'h0);
    check("irq off", 1'b0, irq);
    wr(TDESR_OFF_CTRL, 32'h1);
    wait_done;
    wr(TDESR_OFF_CTRL, 32'h1);
    rchk("start clears", TDESR_OFF_STATUS, 32'h1, 32'h0);
    wait_done;
  endtask

  task automatic t_lod;
    wr(TDESR_OFF_MODE, 32'h0000_8000);
    wr(TDESR_OFF_CTRL, 32'h1);
    wait_done;
    wr(TDESR_OFF_IN1, 32'h0000_0000);
    rchk("write clears", TDESR_OFF_STATUS, 32'h1, 32'h0);
  endtask

  task automatic t_dma_flags;
    @(posedge clk);
    dma.rx_dma_count <= 16'h0;
    dma.rx_dma_next_count <= 16'h0;
    rchk("rx full end", TDESR_OFF_STATUS, 32'h1E, 32'h0A);
    dma.tx_dma_count <= 16'h0;
    dma.tx_dma_next_count <= 16'h0;
    dma.rx_dma_count <= 16'h5;
    dma.rx_count_wr <= 1'b1;
    @(posedge clk);
    dma.rx_count_wr <= 1'b0;
    rchk("tx empty end", TDESR_OFF_STATUS, 32'h1E, 32'h14);
    dma.tx_dma_count <= 16'h3;
    dma.tx_count_wr <= 1'b1;
    @(posedge clk);
    dma.tx_count_wr <= 1'b0;
    rchk("flags clear", TDESR_OFF_STATUS, 32'h1E, 32'h0);
  endtask

  task automatic t_dma_mode;
    wr(TDESR_OFF_MODE, 32'h0000_0200);
    wr(TDESR_OFF_IN1, 32'h0F0F_0F0F);
    wr(TDESR_OFF_IN2, 32'hF0F0_F0F0);
    wr(TDESR_OFF_IN1, 32'h0);
    wait_done;
    rchk("kind 0", TDESR_OFF_STATUS, 32'h3101, 32'h0101);
  endtask

  task automatic t_soft_reset;
    wr(TDESR_OFF_MASK_SET, 32'h100);
    wr(TDESR_OFF_CTRL, 32'h100);
    rchk("status srst", TDESR_OFF_STATUS, 32'hFFFF_FFFF, 32'h0);
    rchk("mask srst", TDESR_OFF_MASK_VIEW, 32'hFFFF_FFFF, 32'h0);
    check("irq srst", 1'b0, irq);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict;
    end
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    dma = '{16'h1, 16'h1, 16'h1, 16'h1, 1'b0, 1'b0};
    sys_rst = 1'b1;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    t_mask;
    t_wo_read;
    t_config;
    t_manual;
    t_lod;
    t_dma_flags;
    t_dma_mode;
    t_soft_reset;
    give_verdict;
  end
endmodule
